// ===== logic/io_port_key_scan.sv
`timescale 1ns/10ps
`include "io_key_map.svh"
// What this block does
// R1 - direction bit one makes pin input, zero makes it drive
// R2 - both direction registers reset to all ones
// R3 - config bit: pull-low on input, open-drain on output
// R4 - strong or weak pull-low is a static strap, not a register
// R5 - data read gives pad for inputs, stored value for outputs
// R6 - data write stores per pin regardless of direction; resets to zero
// R7 - pin-change wake when any input pad differs from stored value
// R8 - software copies pads into data register before sleeping
// R9 - sixteen strobe outputs on shared segment pins, four key inputs
// R10 - four-bit field selects the driven strobe segment, reset zero
// R11 - one bit chooses all segments or only selected one
// R12 - mode bit: irq on key strobe (0) or each scan cycle (1)
// R13 - two-bit scan rate 256/512/1k/2k Hz from slow clock
// R14 - key press passes high to key input; irq gated by enable
// R15 - key high on input wakes from standby when key wake chosen
// R16 - software clears key register before standby with key wake
// R17 - in key use port b read gives key register, zero clears it
// R18 - software sets port b output and zero before halt
// R19 - pad inputs pass a two-stage synchroniser
module io_port_key_scan
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // pads
   input wire logic [7:0] pa_pad_i,
   input wire logic [7:0] pb_pad_i,
   output logic [7:0] pa_o,
   output logic [7:0] pa_oe_o,
   output logic [7:0] pb_o,
   output logic [7:0] pb_oe_o,
   output logic [7:0] pa_pull_low_o,
   output logic [7:0] pb_pull_low_o,
   // static option and slow clock tick input
   input wire logic strong_pull_i,
   output logic strong_pull_o,
   input wire logic slow_clk_i,
   // key strobes, wake, interrupt
   output logic [15:0] key_drive_outputs_o,
   input wire logic key_irq_enable_i,
   output logic wake_o,
   output logic irq_o
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_reg;
   logic rst_n;
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rst_sync_reg <= 2'b00;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_n = rst_sync_reg[1];

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // pad level for inputs, stored bit for outputs
   function automatic logic [7:0] pin_view(input logic [7:0] dir,
                                           input logic [7:0] pad,
                                           input logic [7:0] stor);
      pin_view = (dir & pad) | (~dir & stor); // R5
   endfunction

   function automatic logic [6:0] rate_div(input logic [1:0] r);
      unique case (io_key_pkg::scan_rate_t'(r)) // R13
         io_key_pkg::RATE_256: rate_div = `SCAN_DIV_256;
         io_key_pkg::RATE_512: rate_div = `SCAN_DIV_512;
         io_key_pkg::RATE_1K: rate_div = `SCAN_DIV_1K;
         io_key_pkg::RATE_2K: rate_div = `SCAN_DIV_2K;
      endcase
   endfunction

   io_key_pkg::state_t s_reg, s_next;
   io_key_pkg::reg_req_t req;
   logic [15:0] strobe;
   logic [3:0] key_in;
   logic slow_tick, step, cycle_done, key_hit, key_use;
   logic [7:0] chg_a, chg_b, ev, wclr;

   assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // ------------------------------------------------------------
   // scan and event logic
   // ------------------------------------------------------------
   // strobe pattern: all segments or only the selected one
   generate
      for (genvar g = 0; g < 16; g++)
      begin : g_strobe
         assign strobe[g] = s_reg.ksc[`KSC_ALL_BIT] |
            (s_reg.ksc[`KSC_SEG_HI:`KSC_SEG_LO] == 4'(g)); // R10 R11
      end
   endgenerate

   assign key_use = s_reg.mode[`MODE_KEY_USE_BIT];
   assign key_in = s_reg.pb_s2[3:0] & s_reg.dir_b[3:0]; // R9 R14
   assign key_hit = |key_in;
   assign slow_tick = s_reg.slow_sync[1] & ~s_reg.slow_prev;
   assign step = slow_tick & (s_reg.div_cnt == 7'h00);
   assign cycle_done = step & (s_reg.scan_seg == `SCAN_LAST_SEG);
   // pin-change compares only pins that are inputs
   assign chg_a = (s_reg.pa_s2 ^ s_reg.data_a) & s_reg.dir_a; // R7
   assign chg_b = (s_reg.pb_s2 ^ s_reg.data_b) & s_reg.dir_b &
                  {8{~key_use}}; // R7

   always_comb
   begin
      ev = 8'h00;
      ev[`IRQ_KEY_BIT] = key_use & key_irq_enable_i &
         (s_reg.ksc[`KSC_IMODE_BIT] ? cycle_done : key_hit); // R12 R14
      ev[`IRQ_CHG_BIT] = (|chg_a & s_reg.mode[`MODE_CHG_A_BIT]) |
                         (|chg_b & s_reg.mode[`MODE_CHG_B_BIT]);
      ev[`IRQ_SCAN_BIT] = cycle_done;
   end

   // write-one-to-clear mask
   assign wclr = (req.wr && req.addr == `OFS_IRQ_STATUS) ?
                 req.wdata : 8'h00;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      // two-stage pad and slow clock synchronisers
      s_next.pa_s1 = pa_pad_i; // R19
      s_next.pa_s2 = s_reg.pa_s1; // R19
      s_next.pb_s1 = pb_pad_i; // R19
      s_next.pb_s2 = s_reg.pb_s1; // R19
      s_next.slow_sync = {s_reg.slow_sync[0], slow_clk_i};
      s_next.slow_prev = s_reg.slow_sync[1];
      // scan divider and segment walk
      if (slow_tick)
      begin
         if (s_reg.div_cnt == 7'h00)
         begin
            s_next.div_cnt = rate_div(s_reg.ksc[`KSC_RATE_HI:`KSC_RATE_LO]);
            s_next.scan_seg = s_reg.scan_seg + 4'h1;
         end
         else
            s_next.div_cnt = s_reg.div_cnt - 7'h01;
      end
      // key register holds pressed inputs until cleared
      s_next.key_hold = s_reg.key_hold | {4'h0, key_in};
      // register writes
      if (req.wr)
      begin
         unique case (req.addr)
            `OFS_KEY_SCAN_CTRL: s_next.ksc = req.wdata;
            `OFS_PA_DIR: s_next.dir_a = req.wdata; // R1
            `OFS_PB_DIR: s_next.dir_b = req.wdata; // R1
            `OFS_PA_DATA: s_next.data_a = req.wdata; // R6
            `OFS_PB_DATA:
            begin
               s_next.data_b = req.wdata; // R6
               // zero write clears held keys, new presses still set
               if (key_use && req.wdata == 8'h00)
                  s_next.key_hold = {4'h0, key_in}; // R17
            end
            `OFS_PA_CFG: s_next.cfg_a = req.wdata; // R3
            `OFS_PB_CFG: s_next.cfg_b = req.wdata; // R3
            `OFS_IRQ_MASK: s_next.irq_mask = req.wdata;
            `OFS_MODE_CTRL: s_next.mode = req.wdata;
            default: ;
         endcase
      end
      // sticky status, set wins over clear
      s_next.irq_stat = (s_reg.irq_stat & ~wclr) | ev;
      // read data, valid one cycle after the strobe
      s_next.rdata = 8'h00;
      if (req.rd)
      begin
         unique case (req.addr)
            `OFS_KEY_SCAN_CTRL: s_next.rdata = s_reg.ksc;
            `OFS_PA_DIR: s_next.rdata = s_reg.dir_a;
            `OFS_PB_DIR: s_next.rdata = s_reg.dir_b;
            `OFS_PA_DATA:
               s_next.rdata = pin_view(s_reg.dir_a, s_reg.pa_s2,
                                       s_reg.data_a); // R5
            `OFS_PB_DATA:
               s_next.rdata = key_use ? s_reg.key_hold : // R17
                  pin_view(s_reg.dir_b, s_reg.pb_s2, s_reg.data_b); // R5
            `OFS_PA_CFG: s_next.rdata = s_reg.cfg_a;
            `OFS_PB_CFG: s_next.rdata = s_reg.cfg_b;
            `OFS_IRQ_STATUS: s_next.rdata = s_reg.irq_stat;
            `OFS_IRQ_MASK: s_next.rdata = s_reg.irq_mask;
            `OFS_MODE_CTRL: s_next.rdata = s_reg.mode;
            default: s_next.rdata = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_reg <= '0;
         s_reg.dir_a <= `RST_DIR; // R2
         s_reg.dir_b <= `RST_DIR; // R2
         s_reg.data_a <= `RST_DATA; // R6
         s_reg.data_b <= `RST_DATA; // R6
         s_reg.cfg_a <= `RST_CFG;
         s_reg.cfg_b <= `RST_CFG;
         s_reg.ksc <= `RST_KSC; // R10 R11 R12 R13
         s_reg.div_cnt <= `SCAN_DIV_256;
      end
      else
         s_reg <= s_next;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // open-drain pins drive only a low; push-pull drives data
   assign pa_o = s_reg.data_a;
   assign pb_o = s_reg.data_b;
   assign pa_oe_o = ~s_reg.dir_a & ~(s_reg.cfg_a & s_reg.data_a); // R1 R3
   assign pb_oe_o = ~s_reg.dir_b & ~(s_reg.cfg_b & s_reg.data_b); // R1 R3
   assign pa_pull_low_o = s_reg.dir_a & s_reg.cfg_a; // R3
   assign pb_pull_low_o = s_reg.dir_b & s_reg.cfg_b; // R3
   assign strong_pull_o = strong_pull_i; // R4
   assign key_drive_outputs_o = key_use ? strobe : 16'h0000; // R9
   assign rdata_o = s_reg.rdata;
   assign irq_o = |(s_reg.irq_stat & s_reg.irq_mask);
   // wake is a level while the cause persists
   assign wake_o = (s_reg.mode[`MODE_CHG_A_BIT] & |chg_a) | // R7
                   (s_reg.mode[`MODE_CHG_B_BIT] & |chg_b) | // R7
                   (s_reg.mode[`MODE_KEY_WAKE_BIT] & key_hit); // R15

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_DIR_RESET: assert property (@(posedge clk_i) // R2
      $rose(rst_n) |-> s_reg.dir_a == `RST_DIR && s_reg.dir_b == `RST_DIR)
      else $error("direction not all inputs after reset");
   AST_DIR_OE: assert property (@(posedge clk_i) disable iff (!rst_n) // R1
      (s_reg.dir_a & pa_oe_o) == 8'h00)
      else $error("input pin is driven");
   AST_DATA_WR: assert property (@(posedge clk_i) disable iff (!rst_n) // R6
      wr_i && addr_i == `OFS_PA_DATA |=> s_reg.data_a == $past(wdata_i))
      else $error("port a data write lost");
   AST_READ_A: assert property (@(posedge clk_i) disable iff (!rst_n) // R5
      rd_i && addr_i == `OFS_PA_DATA && !wr_i |=>
      rdata_o == (($past(s_reg.dir_a) & $past(s_reg.pa_s2)) |
                  (~$past(s_reg.dir_a) & $past(s_reg.data_a))))
      else $error("port a read mismatch");
   AST_PULL: assert property (@(posedge clk_i) disable iff (!rst_n) // R3
      (pa_pull_low_o & ~s_reg.dir_a) == 8'h00)
      else $error("pull-low on output pin");
   AST_STROBE_ONE: assert property (@(posedge clk_i) disable iff (!rst_n)
      key_use && !s_reg.ksc[`KSC_ALL_BIT] |->
      $onehot(key_drive_outputs_o)) // R11
      else $error("single segment mode drives many strobes");
   AST_SYNC: assert property (@(posedge clk_i) disable iff (!rst_n) // R19
      ##2 s_reg.pb_s2 == $past(pb_pad_i, 2))
      else $error("pad synchroniser depth wrong");
   AST_WAKE_CHG: assert property (@(posedge clk_i) disable iff (!rst_n)
      s_reg.mode[`MODE_CHG_A_BIT] && |chg_a |-> wake_o) // R7
      else $error("pin change did not wake");
   AST_KEY_CLR: assert property (@(posedge clk_i) disable iff (!rst_n)
      key_use && wr_i && addr_i == `OFS_PB_DATA && wdata_i == `RST_DATA &&
      !key_hit
      |=> s_reg.key_hold == 8'h00) // R17
      else $error("key register not cleared");
   AST_KEY_WAKE: assert property (@(posedge clk_i) disable iff (!rst_n)
      s_reg.mode[`MODE_KEY_WAKE_BIT] && key_hit |-> wake_o) // R15
      else $error("key press did not wake");
endmodule

// ===== logic/io_key_map.svh
`ifndef IO_KEY_MAP_SVH
`define IO_KEY_MAP_SVH
// register offsets
`define OFS_KEY_SCAN_CTRL 8'h14
`define OFS_PA_DIR 8'h30
`define OFS_PB_DIR 8'h31
`define OFS_PA_DATA 8'h34
`define OFS_PB_DATA 8'h35
`define OFS_PA_CFG 8'h38
`define OFS_PB_CFG 8'h39
`define OFS_IRQ_STATUS 8'h3C
`define OFS_IRQ_MASK 8'h3D
`define OFS_MODE_CTRL 8'h3E
// reset values
`define RST_DIR 8'hFF
`define RST_DATA 8'h00
`define RST_CFG 8'h00
`define RST_KSC 8'h00
`define RST_BYTE 8'h00
// key scan control fields
`define KSC_SEG_LO 0
`define KSC_SEG_HI 3
`define KSC_ALL_BIT 4
`define KSC_IMODE_BIT 5
`define KSC_RATE_LO 6
`define KSC_RATE_HI 7
// interrupt status bits
`define IRQ_KEY_BIT 0
`define IRQ_CHG_BIT 1
`define IRQ_SCAN_BIT 2
// mode control bits
`define MODE_CHG_A_BIT 0
`define MODE_CHG_B_BIT 1
`define MODE_KEY_WAKE_BIT 2
`define MODE_KEY_USE_BIT 3
// slow clock 32768 Hz; 256 Hz tap = 128 slow ticks per step
`define SLOW_HZ 32768
`define SCAN_DIV_256 7'h7F
`define SCAN_DIV_512 7'h3F
`define SCAN_DIV_1K 7'h1F
`define SCAN_DIV_2K 7'h0F
`define SCAN_LAST_SEG 4'hF
`endif

// ===== logic/io_key_pkg.sv
package io_key_pkg;
   typedef enum logic [1:0]
   {
      RATE_256 = 2'b00,
      RATE_512 = 2'b01,
      RATE_1K = 2'b10,
      RATE_2K = 2'b11
   } scan_rate_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed
   {
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [7:0] data_a;
      logic [7:0] data_b;
      logic [7:0] cfg_a;
      logic [7:0] cfg_b;
      logic [7:0] ksc;
      logic [7:0] key_hold;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic [7:0] mode;
      logic [7:0] rdata;
      logic [6:0] div_cnt;
      logic [3:0] scan_seg;
      logic [1:0] slow_sync;
      logic slow_prev;
      logic [7:0] pa_s1;
      logic [7:0] pa_s2;
      logic [7:0] pb_s1;
      logic [7:0] pb_s2;
   } state_t;
endpackage

// ===== testbench/pad_matrix_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// far side: outside pad drivers and key matrix
// ----------------------------------------
module pad_matrix_model
(
   // pin drive from the block
   input wire logic [7:0] a_out_i,
   input wire logic [7:0] a_oe_i,
   input wire logic [7:0] b_out_i,
   input wire logic [7:0] b_oe_i,
   input wire logic [15:0] strobe_i,
   // outside world
   input wire logic [7:0] ext_a_i,
   input wire logic [7:0] ext_b_i,
   input wire logic key_on_i,
   input wire logic [3:0] key_seg_i,
   input wire logic [1:0] key_line_i,
   // pad levels back to the block
   output logic [7:0] a_pad_o,
   output logic [7:0] b_pad_o
);
   logic [7:0] hit;
   // a closed key carries its strobe level onto one key input line
   always_comb
   begin
      hit = 8'h00;
      if (key_on_i)
         hit[key_line_i] = strobe_i[key_seg_i];
   end
   // driven pins show the block; released ones the outside source,
   // which is stiffer than the pull-low, so pulls never mask it
   assign a_pad_o = (a_oe_i & a_out_i) | (~a_oe_i & ext_a_i);
   assign b_pad_o = (b_oe_i & b_out_i) | (~b_oe_i & (ext_b_i | hit));
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/10ps
`include "io_key_map.svh"
module testbench;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
   logic [7:0] pa_pad_i, pb_pad_i, pa_o, pa_oe_o, pb_o, pb_oe_o;
   logic [7:0] pa_pull_low_o, pb_pull_low_o;
   logic strong_pull_i = 1'b0, strong_pull_o, slow_clk_i = 1'b0;
   logic [15:0] key_drive_outputs_o;
   logic key_irq_enable_i = 1'b1, wake_o, irq_o, key_on = 1'b0;
   logic [7:0] ext_a = 8'h00, ext_b = 8'h00;
   logic [3:0] key_seg = 4'h0;
   logic [1:0] key_line = 2'h0;
   int ticks = 0, bad_count = 0, compares = 0;
   // ----------------------------------------
   // clocks, design and far side
   // ----------------------------------------
   always #25 clk_i = ~clk_i;
   // slow tick runs far above its real rate so scan cycles fit the run
   always #200 slow_clk_i = ~slow_clk_i;
   always @(posedge slow_clk_i) ticks++;
   io_port_key_scan dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
      .rd_i, .rdata_o, .pa_pad_i, .pb_pad_i, .pa_o, .pa_oe_o, .pb_o,
      .pb_oe_o, .pa_pull_low_o, .pb_pull_low_o, .strong_pull_i,
      .strong_pull_o, .slow_clk_i, .key_drive_outputs_o,
      .key_irq_enable_i, .wake_o, .irq_o);
   pad_matrix_model far (.a_out_i(pa_o), .a_oe_i(pa_oe_o), .b_out_i(pb_o),
      .b_oe_i(pb_oe_o), .strobe_i(key_drive_outputs_o), .ext_a_i(ext_a),
      .ext_b_i(ext_b), .key_on_i(key_on), .key_seg_i(key_seg),
      .key_line_i(key_line), .a_pad_o(pa_pad_i), .b_pad_o(pb_pad_i));
   // ----------------------------------------
   // expectations and bus tasks
   // ----------------------------------------
   function automatic logic [7:0] e_rd(logic [7:0] d, v, e);
      return (e & d) | (v & ~d);
   endfunction
   // open-drain output pins let go of the line while data is one
   function automatic logic [7:0] e_oe(logic [7:0] d, c, v);
      return ~d & ~(c & v);
   endfunction
   function automatic int e_ticks(logic [1:0] r);
      return 16 * (32768 / (256 << r));
   endfunction
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp, input string m);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   task automatic rc(input logic [7:0] a, exp, input string m);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp, m);
   endtask
   task automatic wt(input logic sel, input int n);
      for (int i = 0; i < n; i++)
      begin
         if ((sel ? wake_o : irq_o) === 1'b1)
            return;
         cyc(1);
      end
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      give_verdict();
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [7:0] d, v, c, e, r, b;
      logic [3:0] s;
      int t0;
      void'($urandom(32'hECA61A25));
      e = $urandom;
      ext_a <= e;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      cyc(4);
      chk(pa_oe_o, 8'h00, "reset oe");
      chk(key_drive_outputs_o, 16'h0000, "strobes idle");
      rc(`OFS_PA_DIR, 8'hFF, "dir a");
      rc(`OFS_PB_DIR, 8'hFF, "dir b");
      rc(`OFS_PB_CFG, 8'h00, "cfg b");
      rc(`OFS_KEY_SCAN_CTRL, 8'h00, "ksc");
      rc(`OFS_PA_DATA, e, "pad read");
      wr(8'h20, 8'h5A);
      rc(8'h20, 8'h00, "unmapped");
      wr(`OFS_PA_DIR, 8'h00);
      rc(`OFS_PA_DATA, 8'h00, "data reset");
      $display("test reset done");
      // random directions, data, config and pads on both ports
      for (int i = 0; i < 10; i++)
      begin
         b = i & 1;
         d = $urandom;
         v = $urandom;
         c = $urandom;
         e = $urandom;
         strong_pull_i <= i[1];
         ext_a <= e;
         ext_b <= e;
         wr(`OFS_PA_DIR + b, d);
         wr(`OFS_PA_DATA + b, v);
         wr(`OFS_PA_CFG + b, c);
         cyc(3);
         chk(b ? pb_oe_o : pa_oe_o, e_oe(d, c, v), "oe");
         chk(b ? pb_pull_low_o : pa_pull_low_o, d & c, "pull");
         chk((b ? pb_o : pa_o) & ~d, v & ~d, "drive");
         chk(strong_pull_o, i[1], "strap");
         rc(`OFS_PA_DATA + b, e_rd(d, v, e), "mixed read");
      end
      $display("test ports done");
      wr(`OFS_PA_DIR, 8'hFF);
      cyc(3);
      rd(`OFS_PA_DATA, r);
      wr(`OFS_PA_DATA, r);
      wr(`OFS_MODE_CTRL, 8'h01);
      wr(`OFS_IRQ_MASK, 8'h02);
      wr(`OFS_IRQ_STATUS, 8'hFF);
      cyc(2);
      chk({wake_o, irq_o}, 2'b00, "quiet");
      ext_a <= r ^ (8'h01 << $urandom_range(7));
      wt(1, 8);
      // status bit lands one edge after the wake level
      cyc(1);
      chk(irq_o, 1'b1, "change irq");
      ext_a <= r;
      cyc(4);
      wr(`OFS_IRQ_STATUS, 8'h02);
      cyc(2);
      chk({wake_o, irq_o}, 2'b00, "change cleared");
      $display("test pin change done");
      wr(`OFS_MODE_CTRL, 8'h08);
      wr(`OFS_PB_DIR, 8'hFF);
      ext_b <= 8'h00;
      // the port test left random levels in the key register
      cyc(3);
      wr(`OFS_PB_DATA, 8'h00);
      for (int j = 0; j < 3; j++)
      begin
         s = 4'(j * 7 + j / 2);
         wr(`OFS_KEY_SCAN_CTRL, {4'h0, s});
         cyc(2);
         chk(key_drive_outputs_o, 16'h0001 << s, "one strobe");
         wr(`OFS_KEY_SCAN_CTRL, {4'h1, s});
         cyc(2);
         chk(key_drive_outputs_o, 16'hFFFF, "all strobes");
         wr(`OFS_KEY_SCAN_CTRL, {4'h0, s});
         key_seg <= s + 4'h1;
         key_line <= s[1:0];
         key_on <= 1'b1;
         cyc(4);
         rc(`OFS_PB_DATA, 8'h00, "idle segment");
         key_seg <= s;
         cyc(4);
         rc(`OFS_PB_DATA, 8'h01 << s[1:0], "key held");
         key_on <= 1'b0;
         cyc(4);
         rc(`OFS_PB_DATA, 8'h01 << s[1:0], "key sticky");
         wr(`OFS_PB_DATA, 8'h00);
         rc(`OFS_PB_DATA, 8'h00, "key cleared");
      end
      $display("test key strobe done");
      wr(`OFS_MODE_CTRL, 8'h0C);
      wr(`OFS_IRQ_MASK, 8'h01);
      wr(`OFS_IRQ_STATUS, 8'hFF);
      key_irq_enable_i <= 1'b0;
      cyc(2);
      chk({wake_o, irq_o}, 2'b00, "key quiet");
      key_line <= 2'h2;
      key_on <= 1'b1;
      wt(1, 8);
      chk(irq_o, 1'b0, "irq gated");
      key_irq_enable_i <= 1'b1;
      wt(0, 8);
      key_on <= 1'b0;
      cyc(3);
      wr(`OFS_PB_DATA, 8'h00);
      wr(`OFS_IRQ_STATUS, 8'hFF);
      cyc(2);
      chk({wake_o, irq_o}, 2'b00, "key done");
      // halt entry: port b as zero outputs, outside noise must not wake
      wr(`OFS_MODE_CTRL, 8'h03);
      wr(`OFS_PB_DIR, 8'h00);
      wr(`OFS_PB_DATA, 8'h00);
      ext_b <= $urandom;
      cyc(4);
      chk(wake_o, 1'b0, "halt quiet");
      $display("test key wake done");
      // scan cycle interval measured in slow ticks at every rate
      wr(`OFS_MODE_CTRL, 8'h08);
      wr(`OFS_IRQ_MASK, 8'h05);
      for (int k = 0; k < 4; k++)
      begin
         wr(`OFS_KEY_SCAN_CTRL, {k[1:0], 6'h20});
         wr(`OFS_IRQ_STATUS, 8'hFF);
         cyc(2);
         wt(0, 20000);
         wr(`OFS_IRQ_STATUS, 8'hFF);
         t0 = ticks;
         cyc(2);
         wt(0, 20000);
         t0 = ticks - t0 - e_ticks(k[1:0]);
         chk(t0 >= -2 && t0 <= 2, 1'b1, "scan rate");
      end
      $display("test scan rate done");
      give_verdict();
   end
endmodule
